// ---- rtl/scrb_pkg.sv ----
package scrb_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [4:0] CFG_OFS = 5'h00; // Memory, DMA, pin config
    localparam logic [4:0] IRQ_OFS = 5'h08; // Interrupt source select
    localparam logic [31:0] CFG_RW_MASK = 32'h00df1f03;
    localparam logic [31:0] IRQ_RW_MASK = 32'h0000ffff;
    localparam logic [31:0] CFG_RST = 32'h00000000;
    localparam logic [31:0] IRQ_RST = 32'h00000000;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int MAP_LSB = 0;
    localparam int ADC_BIT = 8;
    localparam int TX_BIT = 9;
    localparam int RX_BIT = 10;
    localparam int TMRA_BIT = 11;
    localparam int TMRB_BIT = 12;
    localparam int PB_LSB = 16;
    localparam int I2C1_BIT = 20;
    localparam int PA_LSB = 22;
    localparam int SRC_W = 4;

    // ****************************************************
    // Encodings and timing
    // ****************************************************
    localparam logic [2:0] SRC_PA = 3'h0;
    localparam logic [2:0] SRC_PB = 3'h1;
    localparam logic [2:0] SRC_PC = 3'h2;
    localparam logic [2:0] SRC_PD = 3'h3;
    localparam logic [2:0] SRC_PF = 3'h5;
    localparam logic [1:0] MAP_SYS = 2'h1;
    localparam logic [1:0] MAP_SRAM = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] STRAP_LOAD_CNT = 2'h2; // Boot sync settled
    localparam logic [1:0] STRAP_DONE_CNT = 2'h3;

    // Memory seen at address zero
    typedef enum logic [1:0] {
        MEM_MAIN,
        MEM_SYSFLASH,
        MEM_SRAM
    } scrb_mem_t;

endpackage

// ---- rtl/scrb_config_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module scrb_config_bank
    import scrb_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Boot pin levels
    input wire logic [1:0] bootPins,
    // Memory alias at address zero
    output logic [1:0] memory_map_select,
    output scrb_mem_t zeroAliasMem,
    // DMA requests in
    input wire logic adcDmaReq,
    input wire logic serial1TxDmaReq,
    input wire logic serial1RxDmaReq,
    input wire logic timerACh1DmaReq,
    input wire logic timerAUpDmaReq,
    input wire logic timerBCh1DmaReq,
    input wire logic timerBUpDmaReq,
    // DMA channel requests 1..5 on bits 0..4
    output logic [4:0] dmaChanReq,
    // Pins steered to the first I2C by alternate function
    input wire logic [3:0] portBAltI2c,
    input wire logic [1:0] portAAltI2c,
    // Fast mode plus drive enables
    output logic [3:0] portBFastPlus,
    output logic [1:0] portAFastPlus,
    output logic i2cFirstAllFastPlus,
    // GPIO pins 0..3 of each port
    input wire logic [3:0] gpioPortA,
    input wire logic [3:0] gpioPortB,
    input wire logic [3:0] gpioPortC,
    input wire logic [3:0] gpioPortD,
    input wire logic [3:0] gpioPortF,
    // External interrupt lines 0..3
    output logic [3:0] irqLine,
    output logic [3:0] irqLineValid
);

    // ****************************************************
    // Elaboration checks
    // ****************************************************
    if (ADDR_W < 5) begin : g_badAddr
        $error("ADDR_W must be at least 5");
    end

    // ****************************************************
    // Declarations
    // ****************************************************
    logic [31:0] cfg_ff; // Configuration register
    logic [31:0] irqSrc_ff; // Interrupt source register
    logic [1:0] bootSync1_ff; // Boot pin first stage
    logic [1:0] bootSync2_ff; // Boot pin second stage
    logic [1:0] strapCnt_ff; // Cycles since reset release
    logic [19:0] pinSync1_ff; // GPIO first stage
    logic [19:0] pinSync2_ff; // GPIO second stage
    logic [3:0] irqLine_ff; // Selected pin levels
    logic [3:0] irqValid_ff; // Line has a legal source
    logic [3:0] nxt_irqLine;
    logic [3:0] nxt_irqValid;
    logic awFull_ff; // Write address held
    logic wFull_ff; // Write data held
    logic [ADDR_W-1:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;
    logic rValid_ff;
    logic [31:0] rData_ff;
    logic [1:0] rResp_ff;
    logic wrFire; // Held write performed this edge
    logic cfgWrite; // Write hits configuration
    logic irqWrite; // Write hits interrupt select
    logic [31:0] byteMask; // Byte lanes from strobes
    logic [ADDR_W-1:0] wrIdx;
    logic [ADDR_W-1:0] rdIdx;
    logic [19:0] pinsRaw;

    assign pinsRaw = {gpioPortF, gpioPortD, gpioPortC, gpioPortB,
        gpioPortA};
    assign wrIdx = awAddr_ff;
    assign rdIdx = s_axi_araddr;
    assign byteMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
        {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
    assign wrFire = awFull_ff && wFull_ff && !bValid_ff;
    assign cfgWrite = wrFire && (wrIdx == ADDR_W'(CFG_OFS));
    assign irqWrite = wrFire && (wrIdx == ADDR_W'(IRQ_OFS));

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ****************************************************
    // AXI4-Lite write channel
    // ****************************************************
    // Each channel accepts once per held transfer
    assign s_axi_awready = !awFull_ff;
    assign s_axi_wready = !wFull_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;

    // Capture address and data in either order
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awFull_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (s_axi_awvalid && !awFull_ff) begin
            awFull_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
        end else if (wrFire) begin
            awFull_ff <= 1'b0;
        end
    end

    // Write data and strobes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wFull_ff <= 1'b0;
            wData_ff <= '0;
            wStrb_ff <= '0;
        end else if (s_axi_wvalid && !wFull_ff) begin
            wFull_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end else if (wrFire) begin
            wFull_ff <= 1'b0;
        end
    end

    // Response after both halves, unmapped gets SLVERR
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bValid_ff <= 1'b0;
            bResp_ff <= RESP_OKAY;
        end else if (wrFire) begin
            bValid_ff <= 1'b1;
            bResp_ff <= (cfgWrite || irqWrite) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
        end
    end

    // ****************************************************
    // AXI4-Lite read channel
    // ****************************************************
    assign s_axi_arready = !rValid_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;

    // Registers read back through their masks
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rValid_ff <= 1'b0;
            rData_ff <= '0;
            rResp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && !rValid_ff) begin
            rValid_ff <= 1'b1;
            if (rdIdx == ADDR_W'(CFG_OFS)) begin
                rData_ff <= cfg_ff & CFG_RW_MASK;
                rResp_ff <= RESP_OKAY;
            end else if (rdIdx == ADDR_W'(IRQ_OFS)) begin
                rData_ff <= irqSrc_ff & IRQ_RW_MASK;
                rResp_ff <= RESP_OKAY;
            end else begin
                rData_ff <= '0;
                rResp_ff <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    // ****************************************************
    // Boot strap capture
    // ****************************************************
    // Boot pins come from outside the clock domain
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bootSync1_ff <= 2'h0;
            bootSync2_ff <= 2'h0;
        end else begin
            bootSync1_ff <= bootPins;
            bootSync2_ff <= bootSync1_ff;
        end
    end

    // Count until the synchroniser carries real pin levels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strapCnt_ff <= 2'h0;
        end else if (cfgWrite && wStrb_ff[0]) begin
            strapCnt_ff <= STRAP_DONE_CNT;
        end else if (strapCnt_ff != STRAP_DONE_CNT) begin
            strapCnt_ff <= strapCnt_ff + 2'h1;
        end
    end

    // ****************************************************
    // Configuration register
    // ****************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= CFG_RST;
        end else if (cfgWrite) begin
            cfg_ff <= ((cfg_ff & ~byteMask) | (wData_ff & byteMask))
                & CFG_RW_MASK;
            if (strapCnt_ff == STRAP_LOAD_CNT && !wStrb_ff[0]) begin
                cfg_ff[MAP_LSB +: 2] <= bootSync2_ff;
            end
        end else if (strapCnt_ff == STRAP_LOAD_CNT) begin
            cfg_ff[MAP_LSB +: 2] <= bootSync2_ff;
        end
    end

    // ****************************************************
    // Memory alias decode
    // ****************************************************
    assign memory_map_select = cfg_ff[MAP_LSB +: 2];

    // Code x0 main flash, 01 system flash, 11 SRAM
    always_comb begin
        case (memory_map_select)
            MAP_SYS: zeroAliasMem = MEM_SYSFLASH;
            MAP_SRAM: zeroAliasMem = MEM_SRAM;
            default: zeroAliasMem = MEM_MAIN;
        endcase
    end

    // ****************************************************
    // DMA request routing
    // ****************************************************
    logic timerAReq;
    logic timerBReq;
    assign timerAReq = timerACh1DmaReq || timerAUpDmaReq;
    assign timerBReq = timerBCh1DmaReq || timerBUpDmaReq;

    // Each channel ORs whatever requests are steered to it
    always_comb begin
        dmaChanReq = 5'h00;
        dmaChanReq[cfg_ff[ADC_BIT] ? 1 : 0] |= adcDmaReq;
        dmaChanReq[cfg_ff[TX_BIT] ? 3 : 1] |= serial1TxDmaReq;
        dmaChanReq[cfg_ff[RX_BIT] ? 4 : 2] |= serial1RxDmaReq;
        // timer A channel 3 or 4
        dmaChanReq[cfg_ff[TMRA_BIT] ? 3 : 2] |= timerAReq;
        // timer B channel 1 or 2
        dmaChanReq[cfg_ff[TMRB_BIT] ? 1 : 0] |= timerBReq;
    end

    // ****************************************************
    // Fast mode plus drive
    // ****************************************************
    assign i2cFirstAllFastPlus = cfg_ff[I2C1_BIT];

    // Per-pin enable, or first I2C takes the pin
    for (genvar p = 0; p < 4; p++) begin : g_portB
        assign portBFastPlus[p] = cfg_ff[PB_LSB + p]
            || (cfg_ff[I2C1_BIT] && portBAltI2c[p]);
    end

    for (genvar p = 0; p < 2; p++) begin : g_portA
        assign portAFastPlus[p] = cfg_ff[PA_LSB + p]
            || (cfg_ff[I2C1_BIT] && portAAltI2c[p]);
    end

    // ****************************************************
    // Interrupt source select
    // ****************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqSrc_ff <= IRQ_RST;
        end else if (irqWrite) begin
            irqSrc_ff <= ((irqSrc_ff & ~byteMask) | (wData_ff & byteMask))
                & IRQ_RW_MASK;
        end
    end

    // GPIO levels are asynchronous to the clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1_ff <= '0;
            pinSync2_ff <= '0;
        end else begin
            pinSync1_ff <= pinsRaw;
            pinSync2_ff <= pinSync1_ff;
        end
    end

    // Line i takes pin i of the port its nibble names
    for (genvar i = 0; i < 4; i++) begin : g_line
        logic [2:0] code;
        assign code = irqSrc_ff[i*SRC_W +: 3];
        always_comb begin
            nxt_irqValid[i] = 1'b1;
            case (code)
                SRC_PA: nxt_irqLine[i] = pinSync2_ff[i];
                SRC_PB: nxt_irqLine[i] = pinSync2_ff[4 + i];
                SRC_PC: nxt_irqLine[i] = pinSync2_ff[8 + i];
                SRC_PD: nxt_irqLine[i] = pinSync2_ff[12 + i];
                SRC_PF: nxt_irqLine[i] = pinSync2_ff[16 + i];
                default: begin
                    nxt_irqLine[i] = 1'b0;
                    nxt_irqValid[i] = 1'b0;
                end
            endcase
        end
    end

    // Registered line outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqLine_ff <= 4'h0;
            irqValid_ff <= 4'h0;
        end else begin
            irqLine_ff <= nxt_irqLine;
            irqValid_ff <= nxt_irqValid;
        end
    end

    assign irqLine = irqLine_ff;
    assign irqLineValid = irqValid_ff;

    // ****************************************************
    // Assertions
    // ****************************************************
    sequence s_wrHeld;
        awFull_ff && wFull_ff && !bValid_ff;
    endsequence

    sequence s_cfgByte0;
        s_wrHeld ##0 (awAddr_ff == ADDR_W'(CFG_OFS)) ##0 wStrb_ff[0];
    endsequence

    property p_mapDecode;
        (memory_map_select[0] == 1'b0) |-> (zeroAliasMem == MEM_MAIN);
    endproperty
    a_mapDecode: assert property (p_mapDecode)
        else $error("alias not main flash for code x0");

    property p_strapLoad;
        (strapCnt_ff == STRAP_LOAD_CNT && !(cfgWrite && wStrb_ff[0]))
            |=> (memory_map_select == $past(bootSync2_ff));
    endproperty
    a_strapLoad: assert property (p_strapLoad)
        else $error("boot selection not loaded");

    property p_swOverride;
        s_cfgByte0 |=> (memory_map_select == $past(wData_ff[1:0]))
            ##1 (strapCnt_ff == STRAP_DONE_CNT);
    endproperty
    a_swOverride: assert property (p_swOverride)
        else $error("software map write lost");

    property p_adcRoute;
        adcDmaReq |-> dmaChanReq[cfg_ff[ADC_BIT] ? 1 : 0];
    endproperty
    a_adcRoute: assert property (p_adcRoute)
        else $error("ADC request misrouted");

    property p_txRoute;
        (serial1TxDmaReq && cfg_ff[TX_BIT]) |-> dmaChanReq[3];
    endproperty
    a_txRoute: assert property (p_txRoute)
        else $error("transmit request not on channel 4");

    property p_rxRoute;
        (serial1RxDmaReq && !cfg_ff[RX_BIT]) |-> dmaChanReq[2];
    endproperty
    a_rxRoute: assert property (p_rxRoute)
        else $error("receive request not on channel 3");

    property p_timerARoute;
        (timerAUpDmaReq && cfg_ff[TMRA_BIT]) |-> dmaChanReq[3];
    endproperty
    a_timerARoute: assert property (p_timerARoute)
        else $error("timer A request not on channel 4");

    property p_timerBRoute;
        (timerBCh1DmaReq && !cfg_ff[TMRB_BIT]) |-> dmaChanReq[0];
    endproperty
    a_timerBRoute: assert property (p_timerBRoute)
        else $error("timer B request not on channel 1");

    property p_portBBoost;
        !cfg_ff[I2C1_BIT] |-> (portBFastPlus == cfg_ff[PB_LSB +: 4]);
    endproperty
    a_portBBoost: assert property (p_portBBoost)
        else $error("port B boost differs from enables");

    property p_portABoost;
        !cfg_ff[I2C1_BIT] |-> (portAFastPlus == cfg_ff[PA_LSB +: 2]);
    endproperty
    a_portABoost: assert property (p_portABoost)
        else $error("port A boost differs from enables");

    property p_line0Select;
        (irqSrc_ff[2:0] == SRC_PF) |=> (irqLine[0] == $past(pinSync2_ff[16]))
            && irqLineValid[0];
    endproperty
    a_line0Select: assert property (p_line0Select)
        else $error("line 0 not fed from port F");

    property p_readZero;
        rValid_ff |-> (rData_ff[31:24] == 8'h00);
    endproperty
    a_readZero: assert property (p_readZero)
        else $error("reserved bits read nonzero");

    property p_wrResp;
        s_wrHeld |=> bValid_ff && !awFull_ff;
    endproperty
    a_wrResp: assert property (p_wrResp)
        else $error("no write response after both halves");

endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import scrb_pkg::*;

    // ****************************************************
    // Bench signals
    // ****************************************************
    logic ref_clk = 1'b0; // 40 MHz bus clock
    logic rst_n = 1'b0; // Active low reset
    logic [4:0] awAddr = '0, arAddr = '0;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic arValid = 1'b0, rReady = 1'b0;
    logic [31:0] wData = '0;
    logic [3:0] wStrb = '0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [1:0] bootPins = 2'h1; // Boot strap: system flash
    logic [1:0] memory_map_select;
    scrb_mem_t zeroAliasMem;
    logic [6:0] dmaIn = '0; // adc, tx, rx, tA ch1, tA up, tB ch1, tB up
    logic [4:0] dmaChanReq;
    logic [3:0] portBAlt = '0, portBFast;
    logic [1:0] portAAlt = '0, portAFast;
    logic allFast;
    logic [3:0] pa = 4'h0, pb = 4'hf, pc = 4'h5, pd = 4'ha, pf = 4'h3;
    logic [3:0] irqLine, irqLineValid;
    int fails = 0; // Mismatch count
    int numChecks = 0; // Comparison count
    int chClr [7] = '{1, 2, 3, 3, 3, 1, 1}; // Channels with route clear
    int chSet [7] = '{2, 4, 5, 4, 4, 2, 2}; // Channels with route set
    int codes [10] = '{0, 1, 2, 3, 5, 4, 6, 7, 8, 13};

    // Free running clock
    always #12.5 ref_clk = ~ref_clk;

    scrb_config_bank scrb_config_bank_inst (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .bootPins(bootPins), .memory_map_select(memory_map_select),
        .zeroAliasMem(zeroAliasMem), .adcDmaReq(dmaIn[0]),
        .serial1TxDmaReq(dmaIn[1]), .serial1RxDmaReq(dmaIn[2]),
        .timerACh1DmaReq(dmaIn[3]), .timerAUpDmaReq(dmaIn[4]),
        .timerBCh1DmaReq(dmaIn[5]), .timerBUpDmaReq(dmaIn[6]),
        .dmaChanReq(dmaChanReq), .portBAltI2c(portBAlt),
        .portAAltI2c(portAAlt), .portBFastPlus(portBFast),
        .portAFastPlus(portAFast), .i2cFirstAllFastPlus(allFast),
        .gpioPortA(pa), .gpioPortB(pb), .gpioPortC(pc), .gpioPortD(pd),
        .gpioPortF(pf), .irqLine(irqLine), .irqLineValid(irqLineValid)
    );

    // ****************************************************
    // Compare and bus tasks
    // ****************************************************
    // Value compare, counts every call
    task automatic chk(input string what, input logic [31:0] expV,
                       input logic [31:0] gotV);
        numChecks++;
        if (gotV !== expV) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, expV, gotV);
        end
    endtask

    // Write one word; address and data offered together
    task automatic regWr(input logic [4:0] a, input logic [31:0] d,
                         input logic [3:0] s, input logic [1:0] expR);
        int n;
        n = 0;
        @(posedge ref_clk);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        forever begin
            @(posedge ref_clk);
            n++;
            if (awValid && awReady === 1'b1) awValid <= 1'b0;
            if (wValid && wReady === 1'b1) wValid <= 1'b0;
            if (bValid === 1'b1 || n > 50) break;
        end
        chk("bvalid", 1'b1, bValid);
        chk("bresp", expR, bResp);
        bReady <= 1'b0;
        awValid <= 1'b0;
        wValid <= 1'b0;
    endtask

    // Read one word and compare data and response
    task automatic regRd(input logic [4:0] a, input logic [31:0] expD,
                         input logic [1:0] expR);
        int n;
        n = 0;
        @(posedge ref_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        forever begin
            @(posedge ref_clk);
            n++;
            if (arValid && arReady === 1'b1) arValid <= 1'b0;
            if (rValid === 1'b1 || n > 50) break;
        end
        chk("rvalid", 1'b1, rValid);
        chk("rdata", expD, rData);
        chk("rresp", expR, rResp);
        rReady <= 1'b0;
        arValid <= 1'b0;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    // Boot strap load and reset values
    task automatic testReset();
        repeat (6) @(posedge ref_clk);
        chk("mapSel", 2'h1, memory_map_select);
        chk("alias", 32'(MEM_SYSFLASH), 32'(zeroAliasMem));
        regRd(5'h00, 32'h00000001, 2'h0);
        regRd(5'h08, 32'h00000000, 2'h0);
        chk("irqValid", 4'hf, irqLineValid);
        $display("test reset done");
    endtask

    // Mid-run reset with an SRAM boot strap
    task automatic testReboot();
        @(posedge ref_clk);
        bootPins <= 2'h3;
        rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk("mapSel", 2'h0, memory_map_select);
        repeat (4) @(posedge ref_clk);
        chk("mapSel", 2'h3, memory_map_select);
        chk("alias", 32'(MEM_SRAM), 32'(zeroAliasMem));
        regRd(5'h08, 32'h00000000, 2'h0);
        $display("test reboot done");
    endtask

    // Software override of the map and reserved bits
    task automatic testCfg();
        logic [1:0] al [4];
        al = '{MEM_MAIN, MEM_SYSFLASH, MEM_MAIN, MEM_SRAM};
        regWr(5'h00, 32'hffffffff, 4'hf, 2'h0);
        regRd(5'h00, 32'h00df1f03, 2'h0);
        for (int i = 0; i < 4; i++) begin
            regWr(5'h00, 32'(i), 4'hf, 2'h0);
            @(posedge ref_clk);
            chk("mapSel", 32'(i), memory_map_select);
            chk("alias", 32'(al[i]), 32'(zeroAliasMem));
        end
        $display("test cfg done");
    endtask

    // Each request alone, routes clear then set
    task automatic testDma();
        int ch;
        for (int s = 0; s < 2; s++) begin
            regWr(5'h00, s ? 32'h00001f00 : 32'h0, 4'hf, 2'h0);
            for (int i = 0; i < 7; i++) begin
                @(posedge ref_clk);
                dmaIn <= 7'h1 << i;
                @(posedge ref_clk);
                ch = s ? chSet[i] : chClr[i];
                chk("dma", 5'h1 << (ch - 1), dmaChanReq);
            end
            @(posedge ref_clk);
            dmaIn <= '0;
        end
        $display("test dma done");
    endtask

    // Per-pin boost, then boost through the first I2C
    task automatic testFmp();
        @(posedge ref_clk);
        portBAlt <= 4'hf;
        portAAlt <= 2'h3;
        regWr(5'h00, 32'h00850000, 4'hf, 2'h0);
        chk("portBFast", 4'h5, portBFast);
        chk("portAFast", 2'h2, portAFast);
        chk("allFast", 1'b0, allFast);
        @(posedge ref_clk);
        portBAlt <= 4'h2;
        portAAlt <= 2'h1;
        regWr(5'h00, 32'h00950000, 4'hf, 2'h0);
        chk("portBFast", 4'h7, portBFast);
        chk("portAFast", 2'h3, portAFast);
        chk("allFast", 1'b1, allFast);
        $display("test fastplus done");
    endtask

    // Every source code on all four lines
    task automatic testIrq();
        logic [3:0] c, expL, expV;
        for (int i = 0; i < 10; i++) begin
            c = 4'(codes[i]);
            case (c[2:0])
                3'h0: expL = pa;
                3'h1: expL = pb;
                3'h2: expL = pc;
                3'h3: expL = pd;
                3'h5: expL = pf;
                default: expL = 4'h0;
            endcase
            expV = (c[2:0] == 3'h4 || c[2:1] == 2'h3) ? 4'h0 : 4'hf;
            regWr(5'h08, {16'h0, {4{c}}}, 4'hf, 2'h0);
            regRd(5'h08, {16'h0, {4{c}}}, 2'h0);
            chk("irqLine", expL, irqLine);
            chk("irqValid", expV, irqLineValid);
        end
        $display("test irq done");
    endtask

    // Unmapped places, reserved bits and byte strobes
    task automatic testErr();
        regWr(5'h04, 32'hffffffff, 4'hf, 2'h2);
        regRd(5'h04, 32'h0, 2'h2);
        regWr(5'h18, 32'hffffffff, 4'hf, 2'h2);
        regWr(5'h08, 32'hffff0000, 4'hf, 2'h0);
        regRd(5'h08, 32'h0, 2'h0);
        regWr(5'h08, 32'h0000ffff, 4'h1, 2'h0);
        regRd(5'h08, 32'h000000ff, 2'h0);
        $display("test errors done");
    endtask

    // ****************************************************
    // Run control
    // ****************************************************
    // Counts and verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        testReset();
        testCfg();
        testDma();
        testFmp();
        testIrq();
        testErr();
        testReboot();
        conclude();
    end

    // Watchdog against a hung handshake
    initial begin
        #(25 * 20000);
        fails++;
        $display("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
